/* File: rtl/fsrc_map.vh */
`ifndef FSRC_MAP_VH
`define FSRC_MAP_VH

// Register byte offsets on the control-byte port.
`define FSRC_OFS_CTRL      8'h00
`define FSRC_OFS_SEL       8'h01
`define FSRC_OFS_CPU_MUL   8'h02
`define FSRC_OFS_CPU_DIV   8'h03
`define FSRC_OFS_REC_MUL   8'h04
`define FSRC_OFS_REC_DIV   8'h05
`define FSRC_OFS_WDT       8'h06
`define FSRC_OFS_STATUS    8'h07

// Control register fields.
`define FSRC_CTRL_PROG_EN  0
`define FSRC_CTRL_OVERRIDE 1
`define FSRC_CTRL_REC_SRC  2
`define FSRC_CTRL_WATCHDOG_ENABLE    3
`define FSRC_CTRL_WD_SCALE 4

// Watchdog register fields.
`define FSRC_WDT_CNT_HI    4
`define FSRC_WDT_FLAG      7

// Status register fields.
`define FSRC_STAT_REC_ACT  5
`define FSRC_STAT_WD_RUN   6

// Reset values.
`define FSRC_RST_BYTE      8'h00
`define FSRC_RST_CODE      5'h00
`define FSRC_RST_DIV       7'h00
`define FSRC_RST_CNT       5'h00

// Offset added to multiplier and divider in the frequency equation.
`define FSRC_NM_OFFSET_N   9'h003
`define FSRC_NM_OFFSET_M   8'h03

// Watchdog tick units in microseconds, and the clock rate in MHz.
`define FSRC_TICK_SHORT_US 150000
`define FSRC_TICK_LONG_US  2500000
`define FSRC_CLK_MHZ       100

`endif

/* File: rtl/fsrc_wdt.v */
`default_nettype none
`include "fsrc_map.vh"

module fsrc_wdt #(
   parameter integer TICK_SHORT_CYC = 15000000,
   parameter integer TICK_LONG_CYC  = 250000000,
   parameter integer PRE_W          = 28
) (
   input  wire       clk_i,
   input  wire       rstn_i,
   input  wire       ce_i,
   input  wire       enable_i,
   input  wire       start_i,
   input  wire       scale_i,
   input  wire [4:0] timeout_i,
   output wire       expire_o,
   output wire       running_o
);

   reg             running_q;
   reg [4:0]       cnt_q;
   reg [PRE_W-1:0] pre_q;
   wire [PRE_W-1:0] tick_last;
   wire            tick;

   assign tick_last = scale_i ? TICK_LONG_CYC[PRE_W-1:0] - 1'b1
                              : TICK_SHORT_CYC[PRE_W-1:0] - 1'b1;
   assign tick      = running_q && (pre_q == tick_last);
   // A zero timeout expires at the first tick rather than wrapping.
   assign expire_o  = ce_i && enable_i && !start_i && tick && (cnt_q <= 5'h01);
   assign running_o = running_q;

   always @(posedge clk_i) begin
      if (!rstn_i) begin
         running_q <= 1'b0;
         cnt_q     <= `FSRC_RST_CNT;
         pre_q     <= {PRE_W{1'b0}};
      end else if (ce_i) begin
         if (!enable_i) begin
            running_q <= 1'b0;
            cnt_q     <= timeout_i;
            pre_q     <= {PRE_W{1'b0}};
         end else if (start_i) begin
            running_q <= 1'b1;
            cnt_q     <= timeout_i;
            pre_q     <= {PRE_W{1'b0}};
         end else if (running_q) begin
            if (tick) begin
               pre_q <= {PRE_W{1'b0}};
               if (cnt_q <= 5'h01) begin
                  running_q <= 1'b0;
                  cnt_q     <= 5'h00;
               end else begin
                  cnt_q <= cnt_q - 5'h01;
               end
            end else begin
               pre_q <= pre_q + 1'b1;
            end
         end
      end
   end

endmodule // fsrc_wdt

`default_nettype wire

/* File: rtl/fsrc_ctl.v */
`default_nettype none
`include "fsrc_map.vh"

module fsrc_ctl #(
   parameter integer TICK_SHORT_CYC = `FSRC_TICK_SHORT_US * `FSRC_CLK_MHZ,
   parameter integer TICK_LONG_CYC  = `FSRC_TICK_LONG_US * `FSRC_CLK_MHZ,
   parameter integer PRE_W          = 28
) (
   input  wire       clk_i,
   input  wire       rstn_i,
   input  wire       ce_i,
   input  wire [4:0] strap_inputs_i,
   input  wire [7:0] reg_addr_i,
   input  wire [7:0] reg_wdata_i,
   input  wire       reg_we_i,
   input  wire       reg_re_i,
   output reg  [7:0] reg_rdata_o,
   output reg  [4:0] freq_code_o,
   output reg        prog_mode_o,
   output reg  [7:0] mult_o,
   output reg  [6:0] div_o,
   output reg  [8:0] mult_plus_o,
   output reg  [7:0] div_plus_o,
   output reg        load_o,
   output reg        recovery_active_o,
   output reg        watchdog_expired_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Strap capture: synchronised, then frozen once after reset release.

   reg [4:0] strap_s1_q;
   reg [4:0] strap_s2_q;
   reg [4:0] strap_s3_q;
   reg [4:0] strap_latched_q;
   reg [2:0] strap_age_q;
   reg       strap_taken_q;

   always @(posedge clk_i) begin
      if (!rstn_i) begin
         strap_s1_q      <= `FSRC_RST_CODE;
         strap_s2_q      <= `FSRC_RST_CODE;
         strap_s3_q      <= `FSRC_RST_CODE;
         strap_latched_q <= `FSRC_RST_CODE;
         strap_age_q     <= 3'h0;
         strap_taken_q   <= 1'b0;
      end else if (ce_i) begin
         strap_s1_q  <= strap_inputs_i;
         strap_s2_q  <= strap_s1_q;
         strap_s3_q  <= strap_s2_q;
         strap_age_q <= {strap_age_q[1:0], 1'b1};
         // Compare only once the stages hold sampled pins, so reset zeros are never taken.
         if (!strap_taken_q && strap_age_q[2] && strap_s2_q == strap_s3_q) begin
            strap_taken_q   <= 1'b1;
            strap_latched_q <= strap_s2_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers.

   reg       prog_freq_en_q;
   reg       pin_choice_override_q;
   reg       recovery_source_choice_q;
   reg       watchdog_enable_q;
   reg       watchdog_tick_scale_q;
   reg [4:0] sel_code_q;
   reg [7:0] cpu_multiplier_q;
   reg [6:0] cpu_divider_q;
   reg [7:0] recovery_multiplier_q;
   reg [6:0] recovery_divider_q;
   reg [4:0] watchdog_timeout_count_q;
   reg       watchdog_expired_flag_q;
   reg       recovery_q;

   wire wr_ctrl = ce_i && reg_we_i && (reg_addr_i == `FSRC_OFS_CTRL);
   wire wr_sel  = ce_i && reg_we_i && (reg_addr_i == `FSRC_OFS_SEL);
   wire wr_cmul = ce_i && reg_we_i && (reg_addr_i == `FSRC_OFS_CPU_MUL);
   wire wr_cdiv = ce_i && reg_we_i && (reg_addr_i == `FSRC_OFS_CPU_DIV);
   wire wr_rmul = ce_i && reg_we_i && (reg_addr_i == `FSRC_OFS_REC_MUL);
   wire wr_rdiv = ce_i && reg_we_i && (reg_addr_i == `FSRC_OFS_REC_DIV);
   wire wr_wdt  = ce_i && reg_we_i && (reg_addr_i == `FSRC_OFS_WDT);
   wire flag_clr = wr_wdt && reg_wdata_i[`FSRC_WDT_FLAG];

   // Any write to the control, select, multiplier or divider registers counts as a frequency change.
   wire freq_change = wr_cmul || wr_cdiv
                   || wr_rmul || wr_rdiv
                   || wr_ctrl || wr_sel;
   wire wd_expire;
   wire wd_running;

   fsrc_wdt #(
      .TICK_SHORT_CYC (TICK_SHORT_CYC),
      .TICK_LONG_CYC  (TICK_LONG_CYC),
      .PRE_W          (PRE_W)
   ) u_wdt (
      .clk_i     (clk_i),
      .rstn_i    (rstn_i),
      .ce_i      (ce_i),
      .enable_i  (watchdog_enable_q),
      .start_i   (freq_change),
      .scale_i   (watchdog_tick_scale_q),
      .timeout_i (watchdog_timeout_count_q),
      .expire_o  (wd_expire),
      .running_o (wd_running)
   );

   always @(posedge clk_i) begin
      if (!rstn_i) begin
         prog_freq_en_q           <= 1'b0;
         pin_choice_override_q    <= 1'b0;
         recovery_source_choice_q <= 1'b0;
         watchdog_enable_q        <= 1'b0;
         watchdog_tick_scale_q    <= 1'b0;
         sel_code_q               <= `FSRC_RST_CODE;
         cpu_multiplier_q         <= `FSRC_RST_BYTE;
         cpu_divider_q            <= `FSRC_RST_DIV;
         recovery_multiplier_q    <= `FSRC_RST_BYTE;
         recovery_divider_q       <= `FSRC_RST_DIV;
         watchdog_timeout_count_q <= `FSRC_RST_CNT;
         watchdog_expired_flag_q  <= 1'b0;
         recovery_q               <= 1'b0;
      end else if (ce_i) begin
         if (wr_ctrl) begin
            prog_freq_en_q           <= reg_wdata_i[`FSRC_CTRL_PROG_EN];
            pin_choice_override_q    <= reg_wdata_i[`FSRC_CTRL_OVERRIDE];
            recovery_source_choice_q <= reg_wdata_i[`FSRC_CTRL_REC_SRC];
            watchdog_enable_q        <= reg_wdata_i[`FSRC_CTRL_WATCHDOG_ENABLE];
            watchdog_tick_scale_q    <= reg_wdata_i[`FSRC_CTRL_WD_SCALE];
         end
         if (wr_sel)
            sel_code_q <= reg_wdata_i[4:0];
         if (wr_cmul)
            cpu_multiplier_q <= reg_wdata_i;
         if (wr_cdiv)
            cpu_divider_q <= reg_wdata_i[6:0];
         if (wr_rmul)
            recovery_multiplier_q <= reg_wdata_i;
         if (wr_rdiv)
            recovery_divider_q <= reg_wdata_i[6:0];
         if (wr_wdt)
            watchdog_timeout_count_q <= reg_wdata_i[`FSRC_WDT_CNT_HI:0];
         // A timeout in the same cycle as the clear keeps the flag set.
         if (wd_expire)
            watchdog_expired_flag_q <= 1'b1;
         else if (flag_clr)
            watchdog_expired_flag_q <= 1'b0;
         // Recovery holds until software acknowledges the timeout.
         if (wd_expire)
            recovery_q <= 1'b1;
         else if (flag_clr)
            recovery_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Frequency source selection.

   reg [4:0] code_d;
   reg       prog_d;
   reg [7:0] mult_d;
   reg [6:0] div_d;
   reg       load_pend_q;

   always @* begin
      code_d = pin_choice_override_q ? sel_code_q : strap_latched_q;
      prog_d = prog_freq_en_q;
      mult_d = cpu_multiplier_q;
      div_d  = cpu_divider_q;
      if (recovery_q) begin
         if (recovery_source_choice_q) begin
            prog_d = 1'b1;
            mult_d = recovery_multiplier_q;
            div_d  = recovery_divider_q;
         end else begin
            prog_d = 1'b0;
            code_d = strap_latched_q;
         end
      end
   end

   always @(posedge clk_i) begin
      if (!rstn_i) begin
         freq_code_o        <= `FSRC_RST_CODE;
         prog_mode_o        <= 1'b0;
         mult_o             <= `FSRC_RST_BYTE;
         div_o              <= `FSRC_RST_DIV;
         mult_plus_o        <= 9'h000;
         div_plus_o         <= 8'h00;
         load_pend_q        <= 1'b0;
         load_o             <= 1'b0;
         recovery_active_o  <= 1'b0;
         watchdog_expired_o <= 1'b0;
         reg_rdata_o        <= `FSRC_RST_BYTE;
      end else if (ce_i) begin
         freq_code_o        <= code_d;
         prog_mode_o        <= prog_d;
         mult_o             <= mult_d;
         div_o              <= div_d;
         // The PLL applies gear * mult_plus / div_plus from these terms.
         mult_plus_o        <= {1'b0, mult_d} + `FSRC_NM_OFFSET_N;
         div_plus_o         <= {1'b0, div_d} + `FSRC_NM_OFFSET_M;
         // Load waits one cycle so that it meets the new terms on the outputs, not stale ones.
         load_pend_q        <= freq_change || wd_expire || (flag_clr && recovery_q);
         load_o             <= load_pend_q;
         recovery_active_o  <= recovery_q;
         watchdog_expired_o <= watchdog_expired_flag_q;
         if (reg_re_i) begin
            case (reg_addr_i)
               `FSRC_OFS_CTRL:    reg_rdata_o <= {3'h0, watchdog_tick_scale_q,
                                                  watchdog_enable_q,
                                                  recovery_source_choice_q,
                                                  pin_choice_override_q, prog_freq_en_q};
               `FSRC_OFS_SEL:     reg_rdata_o <= {3'h0, sel_code_q};
               `FSRC_OFS_CPU_MUL: reg_rdata_o <= cpu_multiplier_q;
               `FSRC_OFS_CPU_DIV: reg_rdata_o <= {1'b0, cpu_divider_q};
               `FSRC_OFS_REC_MUL: reg_rdata_o <= recovery_multiplier_q;
               `FSRC_OFS_REC_DIV: reg_rdata_o <= {1'b0, recovery_divider_q};
               `FSRC_OFS_WDT:     reg_rdata_o <= {watchdog_expired_flag_q, 2'h0,
                                                  watchdog_timeout_count_q};
               `FSRC_OFS_STATUS:  reg_rdata_o <= {1'b0, wd_running, recovery_q,
                                                  strap_latched_q};
               default:           reg_rdata_o <= `FSRC_RST_BYTE;
            endcase
         end
      end
   end

endmodule // fsrc_ctl

`default_nettype wire

/* File: sim/fsrc_host.sv */
`default_nettype none
module fsrc_host (
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   output var  logic [7:0] addr_o,
   output var  logic [7:0] wdata_o,
   output var  logic       we_o,
   output var  logic       re_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      addr_o = 8'h00;
      wdata_o = 8'h00;
      we_o = 1'b0;
      re_o = 1'b0;
   end
   // A released bus shows the inverse of the last value, so a design that
   // samples outside its strobe sees a wrong byte rather than a lucky one.
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr_o = a;
      wdata_o = d;
      we_o = w;
      re_o = !w;
      @(negedge clk_i);
      we_o = 1'b0;
      re_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      acc(1'b0, a, 8'h00);
      q = rdata_i;
   endtask
   task automatic wr_pair(input logic [7:0] a, input logic [7:0] n, input logic [7:0] m);
      wr(a, n);
      wr(a + 8'h01, m);
   endtask
endmodule // fsrc_host
`default_nettype wire

/* File: sim/fsrc_ctl_sva.sv */
`default_nettype none
module fsrc_ctl_sva (
   input wire logic       clk_i,
   input wire logic       rstn_i,
   input wire logic       ce_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       reg_we_i,
   input wire logic       prog_mode_o,
   input wire logic [7:0] mult_o,
   input wire logic [6:0] div_o,
   input wire logic [8:0] mult_plus_o,
   input wire logic [7:0] div_plus_o,
   input wire logic       load_o,
   input wire logic       recovery_active_o,
   input wire logic       watchdog_expired_o
);
   logic wr_c;
   logic en_q;
   assign wr_c = ce_i && reg_we_i;
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         en_q <= 1'b0;
      end else if (wr_c && reg_addr_i == 8'h00) begin
         en_q <= reg_wdata_i[3];
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   property p_load_cpu;
      wr_c && (reg_addr_i == 8'h02 || reg_addr_i == 8'h03) |=> ##1 load_o;
   endproperty
   a_load_cpu: assert property (p_load_cpu) else $error("no load after cpu pair write");
   property p_load_rec;
      wr_c && (reg_addr_i == 8'h04 || reg_addr_i == 8'h05) |=> ##1 load_o;
   endproperty
   a_load_rec: assert property (p_load_rec) else $error("no load after recovery write");
   property p_mult;
      prog_mode_o && !recovery_active_o && wr_c && reg_addr_i == 8'h02
         |=> ##1 (recovery_active_o || mult_o == $past(reg_wdata_i, 2));
   endproperty
   a_mult: assert property (p_mult) else $error("multiplier not taken");
   property p_nplus;
      prog_mode_o |-> mult_plus_o == {1'b0, mult_o} + 9'd3;
   endproperty
   a_nplus: assert property (p_nplus) else $error("multiplier offset wrong");
   property p_mplus;
      prog_mode_o |-> div_plus_o == {1'b0, div_o} + 8'd3;
   endproperty
   a_mplus: assert property (p_mplus) else $error("divider offset wrong");
   property p_prog_on;
      wr_c && reg_addr_i == 8'h00 && reg_wdata_i[0] |=> ##1 (recovery_active_o || prog_mode_o);
   endproperty
   a_prog_on: assert property (p_prog_on) else $error("mode bit did not enable");
   property p_rec_load;
      $rose(recovery_active_o) |-> load_o;
   endproperty
   a_rec_load: assert property (p_rec_load) else $error("recovery without load");
   property p_flag_follow;
      $rose(recovery_active_o) |=> watchdog_expired_o;
   endproperty
   a_flag_follow: assert property (p_flag_follow) else $error("flag not set");
   property p_clear;
      wr_c && reg_addr_i == 8'h06 && reg_wdata_i[7]
         |=> ##1 (!recovery_active_o && !watchdog_expired_o);
   endproperty
   a_clear: assert property (p_clear) else $error("flag clear ignored");
   property p_wd_off;
      !en_q && !$past(en_q) |=> !$rose(recovery_active_o);
   endproperty
   a_wd_off: assert property (p_wd_off) else $error("expiry while stopped");
   c_expire: cover property ($rose(recovery_active_o));
   c_load: cover property (load_o && prog_mode_o);
   c_exit: cover property ($fell(recovery_active_o));
endmodule // fsrc_ctl_sva
bind fsrc_ctl fsrc_ctl_sva fsrc_ctl_sva_i (
   .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .prog_mode_o(prog_mode_o),
   .mult_o(mult_o), .div_o(div_o), .mult_plus_o(mult_plus_o), .div_plus_o(div_plus_o),
   .load_o(load_o), .recovery_active_o(recovery_active_o),
   .watchdog_expired_o(watchdog_expired_o));
`default_nettype wire

/* File: sim/fsrc_ctl_tb_top.sv */
`default_nettype none
module fsrc_ctl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_i, rstn_i, ce_i, we, re, load_o, prog_mode_o, rec_o, exp_o;
   logic [4:0] strap, freq_code_o;
   logic [7:0] addr, wdata, rdata, mult_o, div_plus_o, q;
   logic [6:0] div_o;
   logic [8:0] mult_plus_o;
   int         n_errors = 0;
   int         checks_done = 0;
   int         n;
   fsrc_ctl #(.TICK_SHORT_CYC(20), .TICK_LONG_CYC(50), .PRE_W(8)) fsrc_ctl_i (
      .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .strap_inputs_i(strap),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
      .reg_rdata_o(rdata), .freq_code_o(freq_code_o), .prog_mode_o(prog_mode_o),
      .mult_o(mult_o), .div_o(div_o), .mult_plus_o(mult_plus_o), .div_plus_o(div_plus_o),
      .load_o(load_o), .recovery_active_o(rec_o), .watchdog_expired_o(exp_o));
   fsrc_host fsrc_host_i (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
      .we_o(we), .re_o(re));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic chk(input string what, input logic [8:0] e, input logic [8:0] s);
      checks_done++;
      if (s !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Counts negedges until recovery shows, bounded so a dead timer cannot hang.
   task automatic wait_rec();
      n = 0;
      while (rec_o !== 1'b1 && n < 200) begin
         @(negedge clk_i);
         n++;
      end
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      stop_test();
   end
   initial begin
      rstn_i = 1'b0;
      ce_i = 1'b1;
      strap = 5'h0b;
      repeat (4) @(negedge clk_i);
      rstn_i = 1'b1;
      repeat (6) @(negedge clk_i);
      chk("mode", 0, prog_mode_o);
      chk("code", 5'h0b, freq_code_o);
      fsrc_host_i.rd(8'h00, q);
      chk("ctrl", 8'h00, q);
      fsrc_host_i.rd(8'h07, q);
      chk("status", 8'h0b, q);
      fsrc_host_i.rd(8'h09, q);
      chk("unmapped", 8'h00, q);
      fsrc_host_i.wr(8'h01, 8'h15);
      chk("code", 5'h0b, freq_code_o);
      fsrc_host_i.wr(8'h00, 8'h02);
      @(negedge clk_i);
      chk("code", 5'h15, freq_code_o);
      fsrc_host_i.wr(8'h00, 8'h03);
      @(negedge clk_i);
      chk("mode", 1, prog_mode_o);
      chk("code", 5'h15, freq_code_o);
      fsrc_host_i.wr(8'h02, 8'h61);
      @(negedge clk_i);
      chk("load", 1, load_o);
      chk("mult", 8'h61, mult_o);
      chk("nplus", 9'h064, mult_plus_o);
      fsrc_host_i.wr(8'h03, 8'h5d);
      @(negedge clk_i);
      chk("load", 1, load_o);
      chk("div", 7'h5d, div_o);
      chk("mplus", 8'h60, div_plus_o);
      fsrc_host_i.wr(8'h00, 8'h01);
      @(negedge clk_i);
      chk("code", 5'h0b, freq_code_o);
      fsrc_host_i.wr_pair(8'h04, 8'h20, 8'h10);
      @(negedge clk_i);
      chk("load", 1, load_o);
      fsrc_host_i.wr(8'h06, 8'h02);
      fsrc_host_i.wr(8'h00, 8'h0d);
      fsrc_host_i.wr(8'h01, 8'h15);
      wait_rec();
      chk("short time", 1, n >= 38 && n <= 43);
      chk("rec load", 1, load_o);
      chk("rec mult", 8'h20, mult_o);
      chk("rec div", 7'h10, div_o);
      chk("rec code", 5'h0b, freq_code_o);
      @(negedge clk_i);
      chk("expired", 1, exp_o);
      fsrc_host_i.rd(8'h06, q);
      chk("wdt", 8'h82, q);
      fsrc_host_i.wr(8'h06, 8'h82);
      @(negedge clk_i);
      chk("rec", 0, rec_o);
      fsrc_host_i.wr(8'h00, 8'h05);
      repeat (60) @(negedge clk_i);
      chk("stopped", 0, rec_o);
      fsrc_host_i.wr(8'h06, 8'h01);
      fsrc_host_i.wr(8'h00, 8'h1b);
      fsrc_host_i.wr(8'h01, 8'h15);
      wait_rec();
      chk("long time", 1, n >= 48 && n <= 53);
      chk("rec mode", 0, prog_mode_o);
      chk("rec code", 5'h0b, freq_code_o);
      fsrc_host_i.wr(8'h06, 8'h80);
      fsrc_host_i.rd(8'h06, q);
      chk("wdt", 8'h00, q);
      ce_i = 1'b0;
      fsrc_host_i.wr(8'h02, 8'h33);
      ce_i = 1'b1;
      fsrc_host_i.rd(8'h02, q);
      chk("frozen", 8'h61, q);
      stop_test();
   end
endmodule // fsrc_ctl_tb_top
`default_nettype wire
